/* crs_regset.sv */
// Behaviour
// - A 16-bit program counter holds the address of the fetched instruction.
// - A 16-bit accumulator; byte operations use only its low byte.
// - A 16-bit temporary accumulator is the second operand; bytes use its low byte.
// - A 16-bit index register modifies addresses in indexed addressing.
// - A 16-bit extra pointer addresses a memory location.
// - A 16-bit stack pointer points into the stack area.
// - Status word: upper byte is bank select, lower byte condition flags.
// - Half-carry set on carry or borrow between bits 3 and 4.
// - Interrupt enable one permits interrupts; reset clears it.
// - Request serviced only if its level outranks the level mask; 11 is lowest.
// - Negative flag follows the result's most significant bit.
// - Zero flag set for a zero result, cleared otherwise.
// - Overflow flag set on two's-complement overflow, cleared otherwise.
// - Carry flag set on carry or borrow out of bit 7; word operations here take the carry out of bit 15.
// - Shifts put the shifted-out bit into the carry flag.
// - General registers are 8 bits, eight per bank, in data memory.
// - Number of usable banks is a build parameter: 4, 8 or 16.
// - Bank select chooses the bank that supplies the general registers.
// - 64 Kbyte space: I/O lowest, data above, program code near top.
// - Reset and interrupt vectors sit at the top of the program area.
//
// Decided for this implementation: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
module crs_regset #(
  parameter int NUM_BANKS = 16          // Usable register banks
) (
  input  wire logic        clk,         // Core clock, 20 MHz
  input  wire logic        rstn,        // Asynchronous reset
  input  wire logic        hsel,        // Slave select
  input  wire logic [31:0] haddr,       // Byte address
  input  wire logic [1:0]  htrans,      // Transfer type
  input  wire logic        hwrite,      // Write when high
  input  wire logic [2:0]  hsize,       // Transfer size
  input  wire logic [31:0] hwdata,      // Write data
  input  wire logic        hready,      // Bus ready
  output logic [31:0]      hrdata,      // Read data
  output logic             hreadyout,   // Slave ready
  output logic             hresp,       // Always OKAY
  output logic [15:0]      pc_value,    // Program counter
  output logic [15:0]      ps_value,    // Status word
  output logic             int_accept   // Pending request accepted
);
  import crs_pkg::*;

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  // Keep the bank pointer inside the banks this build provides
  function automatic logic [7:0] bank_of(input logic [7:0] sel);
    bank_of = sel & 8'(NUM_BANKS - 1);
  endfunction

  // Data memory address of a general register
  function automatic logic [15:0] gpr_addr(input logic [7:0] sel,
                                           input logic [2:0] num);
    gpr_addr = CRS_GPR_BASE + {5'h00, bank_of(sel), 3'h0}
             + {13'h0000, num};
  endfunction

  // Classify an address of the 64 Kbyte space
  function automatic crs_region_type region_of(input logic [15:0] a);
    if (a < CRS_IO_TOP)          region_of = CRS_REG_IO;
    else if (a < CRS_DATA_TOP)   region_of = CRS_REG_DATA;
    else if (a >= CRS_VECT_BASE) region_of = CRS_REG_VECT;
    else if (a >= CRS_PROG_BASE) region_of = CRS_REG_PROG;
    else                         region_of = CRS_REG_NONE;
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    CRS_BUS_IDLE = 2'b00,
    CRS_BUS_WAIT = 2'b01,
    CRS_BUS_DONE = 2'b11
  } crs_bus_type;

  crs_bus_type   bus_reg;
  logic [7:0]    addr_reg;
  logic          wr_reg;
  logic          acc_ok_reg;
  logic [31:0]   rdata_reg;
  logic [15:0]   pc_reg;
  logic [15:0]   acc_reg;
  logic [15:0]   tmp_reg;
  logic [15:0]   idx_reg;
  logic [15:0]   exp_reg;
  logic [15:0]   sp_reg;
  logic [7:0]    bank_select_field_reg;
  crs_flags_type condition_flags_reg;
  logic [4:0]    op_reg;
  logic [2:0]    gpr_num_reg;
  logic [1:0]    req_level_reg;
  logic [15:0]   probe_reg;
  logic          take;
  logic          wr_en;
  crs_alu_type   alu;
  logic [31:0]   rd_mux;

  // ----------------------------------------------------------------
  // Bus address phase
  // ----------------------------------------------------------------
  // Only whole-word single transfers are expected; others are taken
  assign take  = hsel && htrans[1] && hready;
  assign wr_en = (bus_reg == CRS_BUS_DONE) && wr_reg && acc_ok_reg;

  // Latch address phase
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      addr_reg   <= 8'h00;
      wr_reg     <= 1'b0;
      acc_ok_reg <= 1'b0;
    end else if (take) begin
      addr_reg   <= haddr[7:0];
      wr_reg     <= hwrite;
      acc_ok_reg <= (haddr[31:8] == 24'h000000) && (hsize == 3'h2);
    end
  end

  // Writes finish at once; reads take one wait state so that a read
  // right after a write sees the newly written value
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      bus_reg <= CRS_BUS_IDLE;
    end else begin
      unique case (bus_reg)
        CRS_BUS_IDLE: begin
          if (take && !hwrite) begin
            bus_reg <= CRS_BUS_WAIT;
          end else if (take) begin
            bus_reg <= CRS_BUS_DONE;
          end
        end
        CRS_BUS_WAIT: begin
          bus_reg <= CRS_BUS_DONE;
        end
        CRS_BUS_DONE: begin
          if (take && !hwrite) begin
            bus_reg <= CRS_BUS_WAIT;
          end else if (take) begin
            bus_reg <= CRS_BUS_DONE;
          end else begin
            bus_reg <= CRS_BUS_IDLE;
          end
        end
        default: begin
          bus_reg <= CRS_BUS_IDLE;
        end
      endcase
    end
  end

  assign hreadyout = (bus_reg != CRS_BUS_WAIT);
  assign hresp     = 1'b0;
  assign hrdata    = rdata_reg;

  // ----------------------------------------------------------------
  // Flag unit
  // ----------------------------------------------------------------
  crs_flag_unit u_flags (
    .word    (op_reg[CRS_OP_WORD_BIT]),
    .op      (crs_op_type'(op_reg[CRS_OP_CODE_LSB +: 3])),
    .acc_val (acc_reg),
    .tmp_val (tmp_reg),
    .cin     (condition_flags_reg.carry),
    .alu     (alu)
  );

  // ----------------------------------------------------------------
  // Dedicated registers
  // ----------------------------------------------------------------
  // Program counter
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pc_reg <= CRS_RST_WORD;
    end else if (wr_en && (addr_reg == CRS_OFS_PC)) begin
      pc_reg <= hwdata[15:0];
    end
  end

  // Operation register; a write runs one operation next cycle
  logic op_go_reg;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      op_reg    <= 5'h00;
      op_go_reg <= 1'b0;
    end else begin
      op_go_reg <= wr_en && (addr_reg == CRS_OFS_OP);
      if (wr_en && (addr_reg == CRS_OFS_OP)) begin
        op_reg <= hwdata[4:0];
      end
    end
  end

  // Accumulator: software load or operation result
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      acc_reg <= CRS_RST_WORD;
    end else if (wr_en && (addr_reg == CRS_OFS_ACC)) begin
      acc_reg <= hwdata[15:0];
    end else if (op_go_reg && alu.write_back) begin
      // Byte results keep the accumulator's upper byte
      if (op_reg[CRS_OP_WORD_BIT]) begin
        acc_reg <= alu.result;
      end else begin
        acc_reg <= {acc_reg[15:8], alu.result[7:0]};
      end
    end
  end

  // Temporary accumulator; second operand of add, subtract and compare
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tmp_reg <= CRS_RST_WORD;
    end else if (wr_en && (addr_reg == CRS_OFS_TMP)) begin
      tmp_reg <= hwdata[15:0];
    end
  end

  // Index register; only software loads it here
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      idx_reg <= CRS_RST_WORD;
    end else if (wr_en && (addr_reg == CRS_OFS_IDX)) begin
      idx_reg <= hwdata[15:0];
    end
  end

  // Extra pointer
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      exp_reg <= CRS_RST_WORD;
    end else if (wr_en && (addr_reg == CRS_OFS_EXP)) begin
      exp_reg <= hwdata[15:0];
    end
  end

  // Stack pointer; no stack traffic in this block, so loads only
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sp_reg <= CRS_RST_WORD;
    end else if (wr_en && (addr_reg == CRS_OFS_SP)) begin
      sp_reg <= hwdata[15:0];
    end
  end

  // ----------------------------------------------------------------
  // Status word
  // ----------------------------------------------------------------
  // Bank select in the upper byte
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      bank_select_field_reg <= CRS_RST_BANK;
    end else if (wr_en && (addr_reg == CRS_OFS_PS)) begin
      bank_select_field_reg <= hwdata[CRS_PS_BANK_LSB +: 8];
    end
  end

  // Condition flags; an operation result wins over nothing else since
  // the operation always lands one cycle after its own bus write
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      condition_flags_reg                      <= '0;
      condition_flags_reg.int_en               <= 1'b0;
      condition_flags_reg.interrupt_level_mask <= CRS_RST_IL;
    end else if (wr_en && (addr_reg == CRS_OFS_PS)) begin
      condition_flags_reg <= crs_flags_type'(hwdata[7:0]);
    end else if (op_go_reg) begin
      condition_flags_reg.half  <= alu.half;
      condition_flags_reg.neg   <= alu.neg;
      condition_flags_reg.zero  <= alu.zero;
      condition_flags_reg.carry <= alu.carry;
      condition_flags_reg.ovf   <= alu.ovf;
    end
  end

  // ----------------------------------------------------------------
  // Bank access, interrupt gate and memory map probe
  // ----------------------------------------------------------------
  // Register number, request level and probe address
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      gpr_num_reg   <= 3'h0;
      req_level_reg <= CRS_RST_IL;
      probe_reg     <= CRS_RST_WORD;
    end else if (wr_en) begin
      if (addr_reg == CRS_OFS_GPR)  gpr_num_reg   <= hwdata[CRS_GPR_NUM_W-1:0];
      if (addr_reg == CRS_OFS_INTQ) req_level_reg <= hwdata[1:0];
      if (addr_reg == CRS_OFS_REGN) probe_reg     <= hwdata[15:0];
    end
  end

  // A lower code outranks a higher one; level 3 never passes mask 3
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      int_accept <= 1'b0;
    end else begin
      int_accept <= condition_flags_reg.int_en
        && (req_level_reg < condition_flags_reg.interrupt_level_mask);
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  // Read multiplexer; unmapped offsets read zero
  always_comb begin
    rd_mux = 32'h00000000;
    unique case (addr_reg)
      CRS_OFS_PC:   rd_mux = {16'h0000, pc_reg};
      CRS_OFS_ACC:  rd_mux = {16'h0000, acc_reg};
      CRS_OFS_TMP:  rd_mux = {16'h0000, tmp_reg};
      CRS_OFS_IDX:  rd_mux = {16'h0000, idx_reg};
      CRS_OFS_EXP:  rd_mux = {16'h0000, exp_reg};
      CRS_OFS_SP:   rd_mux = {16'h0000, sp_reg};
      CRS_OFS_PS:   rd_mux = {16'h0000, ps_value};
      CRS_OFS_OP:   rd_mux = {27'h0000000, op_reg};
      // Bank select picks which bank the register number lands in
      CRS_OFS_GPR:  rd_mux = {16'h0000,
                              gpr_addr(bank_select_field_reg, gpr_num_reg)};
      CRS_OFS_INTQ: rd_mux = {29'h00000000, int_accept, req_level_reg};
      CRS_OFS_REGN: rd_mux = {13'h0000, region_of(probe_reg), probe_reg};
      CRS_OFS_CFG:  rd_mux = 32'(NUM_BANKS);
      default:      rd_mux = 32'h00000000;
    endcase
  end

  // Read data is loaded in the wait state and held until the next read
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdata_reg <= 32'h00000000;
    end else if (bus_reg == CRS_BUS_WAIT) begin
      rdata_reg <= acc_ok_reg ? rd_mux : 32'h00000000;
    end
  end

  // ----------------------------------------------------------------
  // Status outputs
  // ----------------------------------------------------------------
  assign pc_value = pc_reg;
  assign ps_value = {bank_select_field_reg, condition_flags_reg};

endmodule // crs_regset
`default_nettype wire

/* crs_pkg.sv */
`default_nettype none
package crs_pkg;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses, one word each)
  // ----------------------------------------------------------------
  localparam logic [7:0] CRS_OFS_PC    = 8'h00;
  localparam logic [7:0] CRS_OFS_ACC   = 8'h04;
  localparam logic [7:0] CRS_OFS_TMP   = 8'h08;
  localparam logic [7:0] CRS_OFS_IDX   = 8'h0C;
  localparam logic [7:0] CRS_OFS_EXP   = 8'h10;
  localparam logic [7:0] CRS_OFS_SP    = 8'h14;
  localparam logic [7:0] CRS_OFS_PS    = 8'h18;
  localparam logic [7:0] CRS_OFS_OP    = 8'h1C;
  localparam logic [7:0] CRS_OFS_GPR   = 8'h20;
  localparam logic [7:0] CRS_OFS_INTQ  = 8'h24;
  localparam logic [7:0] CRS_OFS_REGN  = 8'h28;
  localparam logic [7:0] CRS_OFS_CFG   = 8'h2C;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CRS_PS_BANK_LSB = 8;   // Upper byte of status word
  localparam int CRS_OP_CODE_LSB = 0;   // Operation code, 3 bits
  localparam int CRS_OP_WORD_BIT = 3;   // 1: 16-bit operation
  localparam int CRS_GPR_NUM_W   = 3;   // Eight registers per bank

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] CRS_RST_WORD = 16'h0000;
  localparam logic [7:0]  CRS_RST_BANK = 8'h00;
  localparam logic [1:0]  CRS_RST_IL   = 2'h3;

  // ----------------------------------------------------------------
  // Memory map of the 64 Kbyte space
  // ----------------------------------------------------------------
  localparam logic [15:0] CRS_IO_TOP    = 16'h0080;
  localparam logic [15:0] CRS_GPR_BASE  = 16'h0100;
  localparam logic [15:0] CRS_DATA_TOP  = 16'h0480;
  localparam logic [15:0] CRS_PROG_BASE = 16'hC000;
  localparam logic [15:0] CRS_VECT_BASE = 16'hFFC0;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    CRS_OP_ADD  = 3'h0,
    CRS_OP_SUB  = 3'h1,
    CRS_OP_CMP  = 3'h2,
    CRS_OP_ROLC = 3'h3,
    CRS_OP_RORC = 3'h4
  } crs_op_type;

  typedef enum logic [2:0] {
    CRS_REG_IO   = 3'h0,
    CRS_REG_DATA = 3'h1,
    CRS_REG_NONE = 3'h3,
    CRS_REG_PROG = 3'h2,
    CRS_REG_VECT = 3'h6
  } crs_region_type;

  // Condition flags, bit 7 down to bit 0
  typedef struct packed {
    logic       half;
    logic       int_en;
    logic [1:0] interrupt_level_mask;
    logic       neg;
    logic       zero;
    logic       ovf;
    logic       carry;
  } crs_flags_type;

  // Result of one flag-unit operation
  typedef struct packed {
    logic [15:0] result;
    logic        write_back;
    logic        half;
    logic        neg;
    logic        zero;
    logic        ovf;
    logic        carry;
  } crs_alu_type;

endpackage
`default_nettype wire

/* crs_flag_unit.sv */
`timescale 1ns/1ps
`default_nettype none
module crs_flag_unit (
  input  wire logic                word,     // 1: 16-bit operation
  input  wire crs_pkg::crs_op_type op,       // Operation
  input  wire logic [15:0]         acc_val,  // First operand
  input  wire logic [15:0]         tmp_val,  // Second operand
  input  wire logic                cin,      // Current carry flag
  output crs_pkg::crs_alu_type     alu       // Result and flags
);
  import crs_pkg::*;

  logic [15:0] a_m;
  logic [15:0] t_m;
  logic [16:0] full;
  logic [4:0]  low;
  logic        sa;
  logic        st;
  logic        msb;

  // ----------------------------------------------------------------
  // Operand masking and arithmetic
  // ----------------------------------------------------------------
  // Byte operations look at the low bytes only
  always_comb begin
    a_m = word ? acc_val : {8'h00, acc_val[7:0]};
    t_m = word ? tmp_val : {8'h00, tmp_val[7:0]};
    sa  = word ? a_m[15] : a_m[7];
    st  = word ? t_m[15] : t_m[7];
    if ((op == CRS_OP_SUB) || (op == CRS_OP_CMP)) begin
      full = {1'b0, a_m} - {1'b0, t_m};
      low  = {1'b0, a_m[3:0]} - {1'b0, t_m[3:0]};
    end else begin
      full = {1'b0, a_m} + {1'b0, t_m};
      low  = {1'b0, a_m[3:0]} + {1'b0, t_m[3:0]};
    end
  end

  // ----------------------------------------------------------------
  // Result and flags
  // ----------------------------------------------------------------
  always_comb begin
    alu            = '0;
    alu.write_back = (op != CRS_OP_CMP);
    alu.half       = low[4];
    unique case (op)
      CRS_OP_ROLC: begin
        alu.result = word ? {a_m[14:0], cin} : {8'h00, a_m[6:0], cin};
        alu.carry  = sa;
        alu.half   = 1'b0;
      end
      CRS_OP_RORC: begin
        alu.result = word ? {cin, a_m[15:1]} : {8'h00, cin, a_m[7:1]};
        alu.carry  = a_m[0];
        alu.half   = 1'b0;
      end
      CRS_OP_SUB, CRS_OP_CMP: begin
        alu.result = word ? full[15:0] : {8'h00, full[7:0]};
        alu.carry  = word ? full[16] : full[8];
        alu.ovf    = (sa != st) && ((word ? full[15] : full[7]) != sa);
      end
      default: begin
        alu.result = word ? full[15:0] : {8'h00, full[7:0]};
        alu.carry  = word ? full[16] : full[8];
        alu.ovf    = (sa == st) && ((word ? full[15] : full[7]) != sa);
      end
    endcase
    msb      = word ? alu.result[15] : alu.result[7];
    alu.neg  = msb;
    alu.zero = (alu.result == 16'h0000);
  end

endmodule // crs_flag_unit
`default_nettype wire

/* crs_regset_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module crs_regset_properties (
  input wire logic        clk,        // Core clock
  input wire logic        rstn,       // Asynchronous reset
  input wire logic        hsel,       // Slave select
  input wire logic [31:0] haddr,      // Byte address
  input wire logic [1:0]  htrans,     // Transfer type
  input wire logic        hwrite,     // Write when high
  input wire logic [2:0]  hsize,      // Transfer size
  input wire logic [31:0] hwdata,     // Write data
  input wire logic        hready,     // Bus ready
  input wire logic [31:0] hrdata,     // Read data
  input wire logic        hreadyout,  // Slave ready
  input wire logic        hresp,      // Response
  input wire logic [15:0] pc_value,   // Program counter
  input wire logic [15:0] ps_value,   // Status word
  input wire logic        int_accept  // Request accepted
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);

  // Address phases that the slave takes; the register accesses below word size only
  wire taken = hsel && htrans[1] && hready;
  wire pc_wr = taken && hwrite && haddr == 32'h0000_0000 && hsize == 3'h2;
  wire ps_wr = taken && hwrite && haddr == 32'h0000_0018 && hsize == 3'h2;
  wire ps_rd = taken && !hwrite && haddr == 32'h0000_0018 && hsize == 3'h2;

  okay_resp_a: assert property (hresp == 1'b0) else $error("response not OKAY");
  read_wait_a: assert property (taken && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state not exactly one cycle");
  write_nowait_a: assert property (taken && hwrite |=> hreadyout)
    else $error("write data phase stalled");
  pc_load_a: assert property (pc_wr ##1 1'b1 |=> pc_value == $past(hwdata[15:0]))
    else $error("program counter did not take written value");
  pc_hold_a: assert property (!$stable(pc_value) |-> $past(pc_wr, 2))
    else $error("program counter changed without a write");
  ps_load_a: assert property (ps_wr ##1 1'b1 |=> ps_value == $past(hwdata[15:0]))
    else $error("status word did not take written value");
  ps_read_a: assert property (ps_rd |=> ##1 hrdata == {16'h0000, ps_value})
    else $error("status word read differs from port");
  accept_en_a: assert property (int_accept |-> $past(ps_value[6]))
    else $error("request accepted while interrupts disabled");
  accept_lvl_a: assert property (int_accept |-> $past(ps_value[5:4]) != 2'h0)
    else $error("request accepted at highest level mask");
endmodule // crs_regset_properties

bind crs_regset crs_regset_properties i_crs_regset_properties (.clk, .rstn, .hsel, .haddr,
  .htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .pc_value,
  .ps_value, .int_accept);
`default_nettype wire

/* crs_regset_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module crs_regset_bench;
  import crs_pkg::*;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'h2;
  logic [2:0]  bsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic [15:0] pc_value;
  logic [15:0] ps_value;
  logic        int_accept;
  int          num_errors = 0;
  int          compares = 0;
  int          cycles = 0;
  logic [31:0] q;

  always #25 clk = ~clk;

  // Eight banks so that bank select wraps inside the pointer
  crs_regset #(.NUM_BANKS(8)) i_crs_regset (.clk(clk), .rstn(rstn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .pc_value(pc_value), .ps_value(ps_value), .int_accept(int_accept));

  // ----------------------------------------------------------------
  // Bus and checking helpers
  // ----------------------------------------------------------------
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Single transfer; waits on hready, the watchdog cuts a hang
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1; htrans <= 2'h2; haddr <= a; hwrite <= w; hsize <= bsize;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    q = hrdata;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rdc(input string name, input logic [31:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    check(name, q, exp);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic test_reset;
    check("pc_port", {16'h0, pc_value}, 32'h0);
    check("accept", {31'h0, int_accept}, 32'h0);
    rdc("ps_rst", {24'h0, CRS_OFS_PS}, 32'h30);
    rdc("intq_rst", {24'h0, CRS_OFS_INTQ}, 32'h3);
  endtask

  // Upper word written as ones must read back zero
  task automatic test_regs;
    for (int i = 0; i < 6; i++) begin
      wr(32'(i * 4), 32'hFFFF_0000 | 32'(16'h1357 * (i + 1)));
      rdc("dedicated", 32'(i * 4), 32'(16'h1357 * (i + 1)));
    end
    check("pc_port", {16'h0, pc_value}, 32'h1357);
  endtask

  task automatic alu(input logic [15:0] a, t, ps, input logic [3:0] op,
                     input logic [15:0] ea, eps);
    wr({24'h0, CRS_OFS_ACC}, {16'h0, a});
    wr({24'h0, CRS_OFS_TMP}, {16'h0, t});
    wr({24'h0, CRS_OFS_PS}, {16'h0, ps});
    wr({24'h0, CRS_OFS_OP}, {28'h0, op});
    rdc("alu_acc", {24'h0, CRS_OFS_ACC}, {16'h0, ea});
    rdc("alu_flags", {24'h0, CRS_OFS_PS}, {16'h0, eps});
  endtask

  // Carries, borrows and rotates; bank, enable and level ride along unchanged
  task automatic test_alu;
    alu(16'h000F, 16'h0001, 16'h0570, 4'h0, 16'h0010, 16'h05F0);
    alu(16'h1280, 16'h0080, 16'h0030, 4'h0, 16'h1200, 16'h0037);
    alu(16'h0000, 16'h0001, 16'h0030, 4'h1, 16'h00FF, 16'h00B9);
    alu(16'h7FFF, 16'h0001, 16'h0030, 4'h8, 16'h8000, 16'h00BA);
    alu(16'h0005, 16'h0005, 16'h0030, 4'h2, 16'h0005, 16'h0034);
    alu(16'h5581, 16'h0000, 16'h0031, 4'h3, 16'h5503, 16'h0031);
    alu(16'h0001, 16'h0000, 16'h0031, 4'h4, 16'h0080, 16'h0039);
    alu(16'h0000, 16'h0001, 16'h0030, 4'h9, 16'hFFFF, 16'h00B9);
    alu(16'h0001, 16'h0002, 16'h0030, 4'h5, 16'h0003, 16'h0030);
  endtask

  // Bank pointer wraps at the bank count
  task automatic test_bank;
    wr({24'h0, CRS_OFS_PS}, 32'h1330);
    #1;
    check("ps_port", {16'h0, ps_value}, 32'h1330);
    wr({24'h0, CRS_OFS_GPR}, 32'h5);
    rdc("gpr_addr", {24'h0, CRS_OFS_GPR}, 32'h011D);
    wr({24'h0, CRS_OFS_PS}, 32'h0730);
    wr({24'h0, CRS_OFS_GPR}, 32'h7);
    rdc("gpr_addr", {24'h0, CRS_OFS_GPR}, 32'h013F);
    rdc("banks", {24'h0, CRS_OFS_CFG}, 32'h8);
  endtask

  // Boundaries of each area of the address space
  task automatic test_region;
    logic [15:0] ra [9] = '{16'h007F, 16'h0080, 16'h047F, 16'h0480, 16'hBFFF,
                            16'hC000, 16'hFFBF, 16'hFFC0, 16'hFFFF};
    logic [2:0]  rg [9] = '{3'h0, 3'h1, 3'h1, 3'h3, 3'h3, 3'h2, 3'h2, 3'h6, 3'h6};
    for (int i = 0; i < 9; i++) begin
      wr({24'h0, CRS_OFS_REGN}, {16'h0, ra[i]});
      rdc("region", {24'h0, CRS_OFS_REGN}, {13'h0, rg[i], ra[i]});
    end
  endtask

  task automatic irq(input logic [15:0] ps, input logic [1:0] lvl, input logic acc);
    wr({24'h0, CRS_OFS_PS}, {16'h0, ps});
    wr({24'h0, CRS_OFS_INTQ}, {30'h0, lvl});
    repeat (2) @(posedge clk);
    #1;
    check("accept", {31'h0, int_accept}, {31'h0, acc});
    rdc("intq", {24'h0, CRS_OFS_INTQ}, {29'h0, acc, lvl});
  endtask

  // Only a strictly higher level passes, and only while enabled
  task automatic test_irq;
    irq(16'h0060, 2'h1, 1'b1);
    irq(16'h0060, 2'h2, 1'b0);
    irq(16'h0020, 2'h1, 1'b0);
    irq(16'h0040, 2'h0, 1'b0);
    irq(16'h0070, 2'h2, 1'b1);
  endtask

  // Unmapped places and sub-word sizes must leave the registers alone
  task automatic test_unmapped;
    wr(32'h0, 32'h1234);
    wr(32'h30, 32'hFFFF);
    rdc("unmapped", 32'h30, 32'h0);
    wr(32'h100, 32'h5555);
    bsize = 3'h0;
    wr(32'h0, 32'h7777);
    bsize = 3'h2;
    rdc("pc_kept", 32'h0, 32'h1234);
  endtask

  task automatic wrap_up;
    $display("compares %0d errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Watchdog well above the few hundred cycles the scenarios need
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors++;
      wrap_up();
    end
  end

  initial begin
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    test_reset();
    test_regs();
    test_alu();
    test_bank();
    test_region();
    test_irq();
    test_unmapped();
    wrap_up();
  end
endmodule // crs_regset_bench
`default_nettype wire
